// File: core/tlpt_unit.v
`timescale 1ns/1ps
`include "tlpt_defines.vh"

module tlpt_unit (
    input wire ref_clk_in,
    input wire nrst_in,
    // Control register access
    input wire [31:0] mode_control_in,
    input wire dir_base_wr_in,
    input wire task_switch_ld_in,
    input wire [31:0] dir_base_wdata_in,
    input wire fault_addr_wr_in,
    input wire [31:0] fault_addr_wdata_in,
    output wire [31:0] directory_base_out,
    output wire [31:0] fault_address_out,
    // Segmentation side
    input wire req_valid_in,
    input wire [31:0] req_lin_addr_in,
    input wire req_write_in,
    input wire [1:0] req_cpl_in,
    output wire req_ready_out,
    output reg resp_valid_out,
    output reg [23:0] resp_phys_addr_out,
    output reg resp_fault_out,
    output reg [7:0] fault_vector_out,
    output reg [15:0] fault_code_out,
    // System memory side
    output wire mem_req_out,
    output reg [23:0] mem_addr_out,
    output reg mem_write_out,
    output reg mem_lock_out,
    output reg [31:0] mem_wdata_out,
    input wire [31:0] mem_rdata_in,
    input wire mem_ack_in
);

//--------------------------------------------------------------
// States and storage
//--------------------------------------------------------------
localparam [6:0] S_IDLE = 7'h01;
localparam [6:0] S_LOOK = 7'h02;
localparam [6:0] S_PDE_RD = 7'h04;
localparam [6:0] S_PDE_WR = 7'h08;
localparam [6:0] S_PTE_RD = 7'h10;
localparam [6:0] S_PTE_WR = 7'h20;
localparam [6:0] S_DONE = 7'h40;

reg [6:0] state_reg;
reg [31:0] dir_base_reg;
reg [31:0] fault_addr_reg;
reg [31:0] lin_reg;
reg write_reg;
reg user_reg;
reg [31:0] pde_reg;
reg [31:0] pte_reg;

// Cache: index is {set, way}, 8 sets of 4 ways
reg tlb_valid [0:31];
reg [19:0] tlb_tag [0:31];
reg [11:0] tlb_frame [0:31];
reg tlb_us [0:31];
reg tlb_rw [0:31];
reg tlb_dirty [0:31];
reg [2:0] plru_reg [0:7];

integer i;
integer j;

//--------------------------------------------------------------
// Functions
//--------------------------------------------------------------
// Page protection check
function prot_fault;
    input user;
    input wr;
    input us;
    input rw;
    begin
        prot_fault = user & (~us | (wr & ~rw));
    end
endfunction

// Tree pseudo-LRU: mark way as recently used
function [2:0] plru_touch;
    input [2:0] old;
    input [1:0] way;
    begin
        if (way[1] == 1'b0) begin
            plru_touch = {old[2], ~way[0], 1'b1};
        end else begin
            plru_touch = {~way[0], old[1], 1'b0};
        end
    end
endfunction

//--------------------------------------------------------------
// Lookup and victim selection
//--------------------------------------------------------------
wire [2:0] set_idx = lin_reg[`TLPT_SET_HI:`TLPT_TBL_LO];
wire [19:0] vpn = lin_reg[`TLPT_DIR_HI:`TLPT_TBL_LO];
reg hit;
reg [1:0] hit_way;
reg [1:0] victim;
reg have_free;
reg [2:0] pl;

// Compare page number against all ways of the set
always @* begin
    hit = 1'b0;
    hit_way = 2'h0;
    have_free = 1'b0;
    victim = 2'h0;
    pl = plru_reg[set_idx];
    for (j = 3; j >= 0; j = j - 1) begin
        if (tlb_valid[{set_idx, j[1:0]}] && tlb_tag[{set_idx, j[1:0]}] == vpn) begin
            hit = 1'b1;
            hit_way = j[1:0];
        end
        if (!tlb_valid[{set_idx, j[1:0]}]) begin
            have_free = 1'b1;
            victim = j[1:0];
        end
    end
    // Refill the matching way so a set never holds one page twice
    if (hit) begin
        victim = hit_way;
    end else if (!have_free) begin
        victim = pl[0] ? {1'b1, pl[2]} : {1'b0, pl[1]};
    end
end

wire [4:0] hit_idx = {set_idx, hit_way};
wire [4:0] fill_idx = {set_idx, victim};
// Write hit on a clean page must walk to set the dirty flag
wire hit_usable = hit & (~write_reg | tlb_dirty[hit_idx]);
wire paging_on = mode_control_in[`TLPT_PAGE_ENABLE_BIT];
wire eff_us = pde_reg[`TLPT_US] & pte_reg[`TLPT_US];
wire eff_rw = pde_reg[`TLPT_RW] & pte_reg[`TLPT_RW];
wire pte_fault = prot_fault(user_reg, write_reg, eff_us, eff_rw);
wire pte_needs_wr = ~pte_reg[`TLPT_ACC] | (write_reg & ~pte_reg[`TLPT_DIRTY]);
wire flush = dir_base_wr_in | task_switch_ld_in;

// Directory and table entry addresses, word aligned
wire [23:0] pde_addr = {dir_base_reg[`TLPT_BASE_HI:`TLPT_BASE_LO],
    lin_reg[`TLPT_DIR_HI:`TLPT_DIR_LO], `TLPT_WORD_PAD};
wire [23:0] pte_addr = {pde_reg[`TLPT_BASE_HI:`TLPT_BASE_LO],
    lin_reg[`TLPT_TBL_HI:`TLPT_TBL_LO], `TLPT_WORD_PAD};

assign req_ready_out = (state_reg == S_IDLE);
// Protection check cycle before the table write-back makes no request
assign mem_req_out = (state_reg == S_PDE_RD) | (state_reg == S_PDE_WR) |
    (state_reg == S_PTE_RD) | ((state_reg == S_PTE_WR) & mem_write_out);
assign directory_base_out = dir_base_reg;
assign fault_address_out = fault_addr_reg;

//--------------------------------------------------------------
// Control registers
//--------------------------------------------------------------
// Directory base keeps only a page aligned 24-bit address
always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        dir_base_reg <= 32'h00000000;
    end else if (flush) begin
        dir_base_reg <= {`TLPT_HIGH_ZERO,
            dir_base_wdata_in[`TLPT_BASE_HI:`TLPT_BASE_LO], `TLPT_LOW_ZERO};
    end
end

//--------------------------------------------------------------
// Walk state machine
//--------------------------------------------------------------
// A hardware fault capture wins over a software write
always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        state_reg <= S_IDLE;
        fault_addr_reg <= 32'h00000000;
        lin_reg <= 32'h00000000;
        write_reg <= 1'b0;
        user_reg <= 1'b0;
        pde_reg <= 32'h00000000;
        pte_reg <= 32'h00000000;
        resp_valid_out <= 1'b0;
        resp_phys_addr_out <= 24'h000000;
        resp_fault_out <= 1'b0;
        fault_vector_out <= 8'h00;
        fault_code_out <= 16'h0000;
        mem_addr_out <= 24'h000000;
        mem_write_out <= 1'b0;
        mem_lock_out <= 1'b0;
        mem_wdata_out <= 32'h00000000;
        for (i = 0; i < 32; i = i + 1) begin
            tlb_valid[i] <= 1'b0;
            tlb_tag[i] <= 20'h00000;
            tlb_frame[i] <= 12'h000;
            tlb_us[i] <= 1'b0;
            tlb_rw[i] <= 1'b0;
            tlb_dirty[i] <= 1'b0;
        end
        for (i = 0; i < 8; i = i + 1) begin
            plru_reg[i] <= 3'h0;
        end
    end else begin
        resp_valid_out <= 1'b0;
        if (fault_addr_wr_in) begin
            fault_addr_reg <= fault_addr_wdata_in;
        end
        // Flush first so a fill in the same cycle still lands
        if (flush) begin
            for (i = 0; i < 32; i = i + 1) begin
                tlb_valid[i] <= 1'b0;
            end
        end
        case (state_reg)
            S_IDLE: begin
                if (req_valid_in) begin
                    lin_reg <= req_lin_addr_in;
                    write_reg <= req_write_in;
                    user_reg <= (req_cpl_in == `TLPT_USER_CPL);
                    state_reg <= S_LOOK;
                end
            end
            S_LOOK: begin
                resp_fault_out <= 1'b0;
                if (!paging_on) begin
                    resp_phys_addr_out <= lin_reg[`TLPT_BASE_HI:0];
                    state_reg <= S_DONE;
                end else if (hit_usable) begin
                    plru_reg[set_idx] <= plru_touch(plru_reg[set_idx], hit_way);
                    resp_phys_addr_out <= {tlb_frame[hit_idx],
                        lin_reg[`TLPT_OFS_HI:0]};
                    if (prot_fault(user_reg, write_reg, tlb_us[hit_idx], tlb_rw[hit_idx])) begin
                        resp_fault_out <= 1'b1;
                        fault_vector_out <= `TLPT_FAULT_VECTOR;
                        fault_code_out <= {`TLPT_CODE_PAD, user_reg, write_reg, 1'b1};
                        fault_addr_reg <= lin_reg;
                    end
                    state_reg <= S_DONE;
                end else begin
                    mem_addr_out <= pde_addr;
                    mem_write_out <= 1'b0;
                    mem_lock_out <= 1'b1;
                    state_reg <= S_PDE_RD;
                end
            end
            S_PDE_RD: begin
                if (mem_ack_in) begin
                    pde_reg <= mem_rdata_in;
                    if (!mem_rdata_in[`TLPT_PRESENT]) begin
                        // Not present: fault, nothing cached
                        mem_lock_out <= 1'b0;
                        resp_fault_out <= 1'b1;
                        fault_vector_out <= `TLPT_FAULT_VECTOR;
                        fault_code_out <= {`TLPT_CODE_PAD, user_reg, write_reg, 1'b0};
                        fault_addr_reg <= lin_reg;
                        state_reg <= S_DONE;
                    end else if (!mem_rdata_in[`TLPT_ACC]) begin
                        // Locked write-back, other bits untouched
                        mem_write_out <= 1'b1;
                        mem_wdata_out <= mem_rdata_in | (32'h1 << `TLPT_ACC);
                        state_reg <= S_PDE_WR;
                    end else begin
                        mem_lock_out <= 1'b0;
                        mem_addr_out <= {mem_rdata_in[`TLPT_BASE_HI:`TLPT_BASE_LO],
                            lin_reg[`TLPT_TBL_HI:`TLPT_TBL_LO], `TLPT_WORD_PAD};
                        mem_lock_out <= 1'b1;
                        state_reg <= S_PTE_RD;
                    end
                end
            end
            S_PDE_WR: begin
                if (mem_ack_in) begin
                    mem_write_out <= 1'b0;
                    mem_addr_out <= pte_addr;
                    state_reg <= S_PTE_RD;
                end
            end
            S_PTE_RD: begin
                if (mem_ack_in) begin
                    pte_reg <= mem_rdata_in;
                    if (!mem_rdata_in[`TLPT_PRESENT]) begin
                        mem_lock_out <= 1'b0;
                        resp_fault_out <= 1'b1;
                        fault_vector_out <= `TLPT_FAULT_VECTOR;
                        fault_code_out <= {`TLPT_CODE_PAD, user_reg, write_reg, 1'b0};
                        fault_addr_reg <= lin_reg;
                        state_reg <= S_DONE;
                    end else begin
                        // Protection is judged next cycle from latched entries
                        state_reg <= S_PTE_WR;
                        mem_write_out <= 1'b0;
                    end
                end
            end
            S_PTE_WR: begin
                if (!mem_write_out) begin
                    if (pte_fault) begin
                        mem_lock_out <= 1'b0;
                        resp_fault_out <= 1'b1;
                        fault_vector_out <= `TLPT_FAULT_VECTOR;
                        fault_code_out <= {`TLPT_CODE_PAD, user_reg, write_reg, 1'b1};
                        fault_addr_reg <= lin_reg;
                        state_reg <= S_DONE;
                    end else if (pte_needs_wr) begin
                        mem_write_out <= 1'b1;
                        mem_wdata_out <= pte_reg | (32'h1 << `TLPT_ACC) |
                            ({31'h0, write_reg} << `TLPT_DIRTY);
                    end
                end
                if ((!mem_write_out && !pte_fault && !pte_needs_wr) ||
                    (mem_write_out && mem_ack_in)) begin
                    // Fill the cache after a fully present walk with no protection fault
                    mem_write_out <= 1'b0;
                    mem_lock_out <= 1'b0;
                    tlb_valid[fill_idx] <= 1'b1;
                    tlb_tag[fill_idx] <= vpn;
                    tlb_frame[fill_idx] <= pte_reg[`TLPT_BASE_HI:`TLPT_BASE_LO];
                    tlb_us[fill_idx] <= eff_us;
                    tlb_rw[fill_idx] <= eff_rw;
                    tlb_dirty[fill_idx] <= pte_reg[`TLPT_DIRTY] | write_reg;
                    plru_reg[set_idx] <= plru_touch(plru_reg[set_idx], victim);
                    resp_phys_addr_out <= {pte_reg[`TLPT_BASE_HI:`TLPT_BASE_LO],
                        lin_reg[`TLPT_OFS_HI:0]};
                    state_reg <= S_DONE;
                end
            end
            S_DONE: begin
                resp_valid_out <= 1'b1;
                state_reg <= S_IDLE;
            end
            default: begin
                state_reg <= S_IDLE;
            end
        endcase
    end
end

endmodule // tlpt_unit

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    reg ref_clk_in = 1'b0;
    reg nrst_in = 1'b0;
    reg [31:0] mode_control_in = 32'h0;
    reg dir_base_wr_in = 1'b0;
    reg task_switch_ld_in = 1'b0;
    reg [31:0] dir_base_wdata_in = 32'h0;
    reg fault_addr_wr_in = 1'b0;
    reg [31:0] fault_addr_wdata_in = 32'h0;
    reg req_valid_in = 1'b0;
    reg [31:0] req_lin_addr_in = 32'h0;
    reg req_write_in = 1'b0;
    reg [1:0] req_cpl_in = 2'h0;
    reg [3:0] dly = 4'h0;
    wire [31:0] directory_base_out, fault_address_out, mem_wdata_out, mem_rdata_in;
    wire req_ready_out, resp_valid_out, resp_fault_out, mem_req_out, mem_write_out;
    wire mem_lock_out, mem_ack_in;
    wire [23:0] resp_phys_addr_out, mem_addr_out;
    wire [7:0] fault_vector_out;
    wire [15:0] fault_code_out;
    integer num_errors = 0;
    integer total_checks = 0;
    integer nacc = 0;
    integer k, n;
    tlpt_unit dut_u (.*);
    tlpt_mem_model mem_u (.clk_in(ref_clk_in), .req_in(mem_req_out), .addr_in(mem_addr_out),
        .write_in(mem_write_out), .wdata_in(mem_wdata_out), .dly_in(dly),
        .rdata_out(mem_rdata_in), .ack_out(mem_ack_in));
    always #2 ref_clk_in = ~ref_clk_in;
    // Count finished memory accesses
    always @(posedge ref_clk_in) if (mem_req_out && mem_ack_in) nacc = nacc + 1;
    // -----------------------------------------
    // Shared tasks
    // -----------------------------------------
    task chk(input [31:0] s, input [31:0] e);
        begin
            total_checks = total_checks + 1;
            if (s !== e) begin
                num_errors = num_errors + 1;
                $display("mismatch at %0t: got %h expected %h", $time, s, e);
            end
        end
    endtask
    task load_base(input [31:0] v, input ts);
        begin
            @(negedge ref_clk_in);
            {dir_base_wdata_in, dir_base_wr_in, task_switch_ld_in} = {v, !ts, ts};
            @(negedge ref_clk_in);
            {dir_base_wr_in, task_switch_ld_in} = 2'h0;
        end
    endtask
    task xlate(input [31:0] a, input w, input [1:0] c, input ef, input [23:0] ep);
        integer t;
        begin
            @(negedge ref_clk_in);
            {req_valid_in, req_lin_addr_in, req_write_in, req_cpl_in} = {1'b1, a, w, c};
            @(negedge ref_clk_in);
            req_valid_in = 1'b0;
            for (t = 0; t < 200 && resp_valid_out !== 1'b1; t = t + 1) @(negedge ref_clk_in);
            chk(resp_valid_out, 1'b1);
            chk(resp_fault_out, ef);
            if (!ef) chk(resp_phys_addr_out, ep);
        end
    endtask
    // -----------------------------------------
    // Scenarios
    // -----------------------------------------
    task t_regs;
        begin
            chk(directory_base_out, 32'h0);
            load_base(32'hff123abc, 1'b0);
            chk(directory_base_out, 32'h00123000);
            @(negedge ref_clk_in);
            {fault_addr_wdata_in, fault_addr_wr_in} = {32'hdeadbeef, 1'b1};
            @(negedge ref_clk_in);
            fault_addr_wr_in = 1'b0;
            chk(fault_address_out, 32'hdeadbeef);
        end
    endtask
    task t_walk;
        begin
            xlate(32'h12345678, 1'b0, 2'h0, 1'b0, 24'h345678);
            load_base(32'h00001000, 1'b0);
            mode_control_in = 32'h80000000;
            dly = 4'h2;
            mem_u.mem[16'h448] = 32'h00002e07;
            mem_u.mem[16'hb45] = 32'hffabc007;
            xlate(32'h12345678, 1'b0, 2'h3, 1'b0, 24'habc678);
            chk(mem_u.mem[16'h448], 32'h00002e27);
            chk(mem_u.mem[16'hb45], 32'hffabc027);
            xlate(32'h12345abc, 1'b1, 2'h3, 1'b0, 24'habcabc);
            chk(mem_u.mem[16'hb45], 32'hffabc067);
            dly = 4'h0;
            n = nacc;
            xlate(32'h12345000, 1'b0, 2'h3, 1'b0, 24'habc000);
            chk(nacc - n, 0);
            load_base(32'h00001000, 1'b1);
            xlate(32'h12345000, 1'b0, 2'h3, 1'b0, 24'habc000);
            chk(nacc - n, 2);
        end
    endtask
    task t_fault;
        begin
            for (k = 0; k < 2; k = k + 1) begin
                n = nacc;
                xlate(32'h00400123, 1'b0, 2'h0, 1'b1, 24'h0);
                chk(nacc - n, 1);
            end
            chk(fault_code_out, 16'h0000);
            chk(fault_vector_out, 8'h0e);
            chk(fault_address_out, 32'h00400123);
            mem_u.mem[16'h402] = 32'h00002007;
            mem_u.mem[16'h403] = 32'h00002003;
            mem_u.mem[16'h800] = 32'h00005005;
            xlate(32'h00800010, 1'b0, 2'h3, 1'b0, 24'h005010);
            xlate(32'h00800010, 1'b1, 2'h3, 1'b1, 24'h0);
            chk(fault_code_out, 16'h0007);
            xlate(32'h00800010, 1'b1, 2'h0, 1'b0, 24'h005010);
            xlate(32'h00c00010, 1'b0, 2'h3, 1'b1, 24'h0);
            chk(fault_code_out, 16'h0005);
        end
    endtask
    task t_lru;
        begin
            load_base(32'h00001000, 1'b0);
            mem_u.mem[16'h400] = 32'h00003007;
            for (k = 0; k < 5; k = k + 1) mem_u.mem[16'hc00 + 8 * k] = (k + 16) * 4096 + 7;
            for (k = 0; k < 5; k = k + 1) xlate(k << 15, 1'b0, 2'h0, 1'b0, (k + 16) << 12);
            n = nacc;
            for (k = 1; k < 5; k = k + 1) xlate(k << 15, 1'b0, 2'h0, 1'b0, (k + 16) << 12);
            chk(nacc - n, 0);
            xlate(32'h0, 1'b0, 2'h0, 1'b0, 24'h010000);
            chk(nacc - n, 2);
            // Most recently used page must survive the eviction
            xlate(32'h00020000, 1'b0, 2'h0, 1'b0, 24'h014000);
            chk(nacc - n, 2);
        end
    endtask
    task close_out;
        begin
            if (num_errors == 0 && total_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // Reset, then the scenarios in order
    initial begin
        repeat (3) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        nrst_in = 1'b1;
        t_regs;
        t_walk;
        t_fault;
        t_lru;
        close_out;
    end
    // Watchdog against a hung handshake
    initial begin
        #100000;
        num_errors = num_errors + 1;
        close_out;
    end
endmodule // tb_top

// File: dv/tlpt_mem_model.sv
`timescale 1ns/1ps
// -----------------------------------------
// Page table memory on the far side
// -----------------------------------------
module tlpt_mem_model (
    input wire clk_in,
    input wire req_in,
    input wire [23:0] addr_in,
    input wire write_in,
    input wire [31:0] wdata_in,
    input wire [3:0] dly_in,
    output wire [31:0] rdata_out,
    output reg ack_out
);
    reg [31:0] mem [0:16383]; // Word array holding 4 KiB tables
    reg [31:0] rd_reg = 32'h0;
    reg [3:0] cnt_reg = 4'h0;
    integer i;
    // Released data lines show the inverse of the last word
    assign rdata_out = ack_out ? rd_reg : ~rd_reg;
    initial begin
        ack_out = 1'b0;
        for (i = 0; i < 16384; i = i + 1) mem[i] = 32'h0;
    end
    // One ack per access after dly_in wait cycles
    always @(posedge clk_in) begin
        ack_out <= 1'b0;
        if (req_in && !ack_out) begin
            if (cnt_reg == dly_in) begin
                ack_out <= 1'b1;
                cnt_reg <= 4'h0;
                if (write_in) mem[addr_in[15:2]] <= wdata_in; // Locked write-back
                else rd_reg <= mem[addr_in[15:2]];
            end else cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule // tlpt_mem_model

// File: dv/tlpt_props.sv
`timescale 1ns/1ps
module tlpt_props (
    input wire ref_clk_in,
    input wire nrst_in,
    input wire [31:0] mode_control_in,
    input wire [31:0] directory_base_out,
    input wire [31:0] fault_address_out,
    input wire req_valid_in,
    input wire [31:0] req_lin_addr_in,
    input wire req_write_in,
    input wire [1:0] req_cpl_in,
    input wire req_ready_out,
    input wire resp_valid_out,
    input wire [23:0] resp_phys_addr_out,
    input wire resp_fault_out,
    input wire [15:0] fault_code_out,
    input wire mem_req_out,
    input wire [23:0] mem_addr_out,
    input wire mem_write_out,
    input wire mem_lock_out,
    input wire [31:0] mem_wdata_out,
    input wire [31:0] mem_rdata_in,
    input wire mem_ack_in
);
    reg [31:0] lin_q, pde_q, rd_q;
    reg [23:0] ra_q;
    reg [1:0] nrd;
    reg w_q, u_q;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    // Request and last read word tracking
    always @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            {lin_q, pde_q, rd_q, ra_q, nrd, w_q, u_q} <= 'h0;
        end else if (req_valid_in && req_ready_out) begin
            {nrd, lin_q, w_q, u_q} <= {2'h0, req_lin_addr_in, req_write_in, &req_cpl_in};
        end else if (mem_req_out && mem_ack_in && !mem_write_out) begin
            nrd <= nrd + 2'h1;
            rd_q <= mem_rdata_in;
            ra_q <= mem_addr_out;
            if (nrd == 2'h0) pde_q <= mem_rdata_in;
        end
    end
    a_off_passthru: assert property (req_valid_in && req_ready_out && !mode_control_in[31]
        |-> ##3 resp_valid_out && !resp_fault_out && {8'h00, resp_phys_addr_out}
        == ($past(req_lin_addr_in, 3) & 32'h00ffffff)) else $error("paging off bad");
    a_pde_addr: assert property (mem_req_out && !mem_write_out && nrd == 2'h0
        |-> mem_addr_out == {directory_base_out[23:12], lin_q[31:22], 2'h0})
        else $error("directory entry address wrong");
    a_pte_addr: assert property (mem_req_out && !mem_write_out && nrd == 2'h1
        |-> pde_q[0] && mem_addr_out == {pde_q[23:12], lin_q[21:12], 2'h0})
        else $error("table entry address wrong");
    a_write_locked: assert property (mem_req_out && mem_write_out |-> mem_lock_out)
        else $error("unlocked write-back");
    a_write_same_addr: assert property ($rose(mem_req_out && mem_write_out)
        |-> mem_addr_out == ra_q) else $error("write-back address moved");
    a_write_sets_acc: assert property (mem_req_out && mem_write_out |-> mem_wdata_out[5])
        else $error("accessed flag not set");
    a_soft_bits_kept: assert property (mem_req_out && mem_write_out
        |-> mem_wdata_out[31:9] == rd_q[31:9]) else $error("entry bits altered");
    a_fault_addr: assert property (resp_valid_out && resp_fault_out
        |-> fault_address_out == lin_q) else $error("fault address wrong");
    a_fault_code: assert property (resp_valid_out && resp_fault_out
        |-> fault_code_out[2:1] == {u_q, w_q}) else $error("fault code wrong");
endmodule // tlpt_props
bind tlpt_unit tlpt_props u_props (.*);

// File: shared/tlpt_defines.vh
// Functional notes
// - Linear bits 31..22 index the page directory entry.
// - Linear bits 21..12 index the page table entry.
// - Directory entry top 20 bits give the 4 KiB aligned table base.
// - Table entry top 20 bits give frame base; linear 11..0 is offset.
// - Only low 24 physical address bits reach the address pins.
// - Directory base holds a 24-bit page aligned address, low 12 bits zero.
// - Writing the directory base or a task switch load flushes the cache; a walk fill in the same cycle still lands.
// - Last faulting 32-bit linear address is kept in the fault register.
// - Entries are used only when present is one; else bits are software's.
// - Accessed flag set in directory and table entry before the access.
// - Dirty flag of the table entry set before any write to the page.
// - Flag updates use locked read-modify-write; other masters lock too.
// - The three software bits 11..9 are never changed or interpreted.
// - Level 3 is user; levels 0..2 are supervisor and skip protection checks.
// - Effective rights are the more restrictive of both entries.
// - Translation cache has four ways and 32 entries.
// - Upper 20 linear bits match cached tags; hit drives 24-bit address.
// - On a miss fetch directory entry, then table entry only if present.
// - Pages, directories and tables are 4 KiB with 1024 word entries.
// - Translation happens only while mode control bit 31 is set.
// - Not present entry or protection violation raises page fault 14.
// - Fault code bit 0 protection, bit 1 write, bit 2 user.
// - A successful walk fills the cache with page number and frame.
`ifndef TLPT_DEFINES_VH
`define TLPT_DEFINES_VH
// Entry fields
`define TLPT_PRESENT 0
`define TLPT_RW 1
`define TLPT_US 2
`define TLPT_ACC 5
`define TLPT_DIRTY 6
`define TLPT_BASE_HI 23
`define TLPT_BASE_LO 12
// Linear address fields
`define TLPT_DIR_HI 31
`define TLPT_DIR_LO 22
`define TLPT_TBL_HI 21
`define TLPT_TBL_LO 12
`define TLPT_OFS_HI 11
`define TLPT_SET_HI 14
// Misc
`define TLPT_USER_CPL 2'h3
`define TLPT_FAULT_VECTOR 8'h0e
`define TLPT_CODE_PAD 13'h0000
`define TLPT_WORD_PAD 2'h0
`define TLPT_LOW_ZERO 12'h000
`define TLPT_HIGH_ZERO 8'h00
`define TLPT_PAGE_ENABLE_BIT 31
`endif
